// *** src/ith_pkg.sv ***
package ith_pkg;

  // register byte offsets
  localparam logic [4:0] ITH_REG_CTRL = 5'h00;
  localparam logic [4:0] ITH_REG_WDATA = 5'h04;
  localparam logic [4:0] ITH_REG_RDATA = 5'h08;
  localparam logic [4:0] ITH_REG_STATUS = 5'h0C;
  localparam logic [4:0] ITH_REG_HRESET = 5'h10;
  localparam logic [4:0] ITH_REG_ERRC = 5'h14;

  // control field positions
  localparam int ITH_CTRL_GO = 0;
  localparam int ITH_CTRL_READ = 1;
  localparam int ITH_CTRL_BLOCK = 2;
  localparam int ITH_CTRL_ALT = 3;
  localparam int ITH_CTRL_ADDR = 4;

  // status field positions
  localparam int ITH_ST_BUSY = 0;
  localparam int ITH_ST_DONE = 1;
  localparam int ITH_ST_IRQ = 2;
  localparam int ITH_ST_IRQ_SEEN = 3;
  localparam int ITH_ST_WORD = 4;
  localparam int ITH_ST_DASP = 5;
  localparam int ITH_ST_PDIAG = 6;
  localparam int ITH_ST_WFAULT = 7;
  localparam int ITH_ST_RESET = 8;

  // error cause layout
  localparam int ITH_ERR_BAD_BLOCK = 7;
  localparam int ITH_ERR_UNCORRECTABLE = 6;
  localparam int ITH_ERR_NOT_FOUND = 4;
  localparam int ITH_ERR_ABORTED = 2;
  localparam int ITH_ERR_GENERAL = 0;
  localparam logic [7:0] ITH_ERR_ZERO_MASK = 8'h2A;

  // task file selects under the first chip select
  localparam logic [2:0] ITH_TF_DATA = 3'h0;
  localparam logic [2:0] ITH_TF_ERROR = 3'h1;
  localparam logic [2:0] ITH_TF_COMMAND = 3'h7;
  localparam int ITH_TF_ERR_BIT = 0;

  // timing
  localparam int ITH_CLK_PERIOD_NS = 100;
  localparam int ITH_T_SETUP_NS = 70;
  localparam int ITH_T_PULSE_NS = 165;
  localparam int ITH_T_RECOVER_NS = 240;
  localparam int ITH_T_RESET_NS = 25000;
  localparam int ITH_SYNC_STAGES = 2;
  localparam int ITH_SETUP_CYC = (ITH_T_SETUP_NS + ITH_CLK_PERIOD_NS - 1) / ITH_CLK_PERIOD_NS;
  localparam int ITH_PULSE_CYC = (ITH_T_PULSE_NS + ITH_CLK_PERIOD_NS - 1) / ITH_CLK_PERIOD_NS;
  localparam int ITH_RECOVER_CYC =
    (ITH_T_RECOVER_NS + ITH_CLK_PERIOD_NS - 1) / ITH_CLK_PERIOD_NS;
  localparam int ITH_RESET_CYC = (ITH_T_RESET_NS + ITH_CLK_PERIOD_NS - 1) / ITH_CLK_PERIOD_NS;
  localparam int ITH_SYNC_W = 21;

  typedef enum logic [2:0] {ST_IDLE, ST_SETUP, ST_STROBE, ST_RECOVER, ST_RESET} ith_phase_e;

  typedef struct packed {
    logic reset_n;
    logic cs0_n;
    logic cs1_n;
    logic [2:0] da;
    logic dior_n;
    logic diow_n;
    logic [15:0] dd_out;
    logic dd_oe;
  } ith_pins_s;

  typedef struct packed {
    logic is_read;
    logic is_block;
    logic is_alt;
    logic [2:0] addr;
  } ith_cmd_s;

  typedef struct packed {
    ith_phase_e phase;
    logic [8:0] cnt;
    ith_pins_s pins;
    ith_cmd_s cmd;
    logic [15:0] wdata;
    logic [15:0] rdata;
    logic [7:0] err_cause;
    logic done;
    logic irq_prev;
    logic irq_seen;
    logic width_fault;
    logic wait_req;
    logic [31:0] readdata;
  } ith_state_s;

  localparam ith_pins_s ITH_PINS_IDLE = '{reset_n: 1'b1, cs0_n: 1'b1, cs1_n: 1'b1,
    da: 3'h0, dior_n: 1'b1, diow_n: 1'b1, dd_out: 16'h0000, dd_oe: 1'b0};

endpackage : ith_pkg

// *** src/ith_sync.sv ***
`timescale 1ns/10ps
module ith_sync #(
  parameter int WIDTH = 1
) (
  // clock and reset
  input wire logic clock_i,
  input wire logic rstn_i,
  // data
  input wire logic [WIDTH-1:0] async_i,
  output logic [WIDTH-1:0] sync_o
);

  logic [WIDTH-1:0] stage1;

  // two flops, first read only by second
  always_ff @(posedge clock_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      stage1 <= '0;
      sync_o <= '0;
    end
    else
    begin
      stage1 <= async_i;
      sync_o <= stage1;
    end
  end

endmodule : ith_sync

// *** src/ith_host.sv ***
// Operation
// - host grounds address lines above three
// - first select task file, second control
// - task file accesses bytes on low lane
// - data port transfers use all sixteen bits
// - host pulses read strobe to fetch data
// - low reset pin resets the device
`timescale 1ns/10ps
module ith_host
  import ith_pkg::*;
#(
  parameter int SETUP_CYC = ITH_SETUP_CYC,
  parameter int PULSE_CYC = ITH_PULSE_CYC,
  parameter int RECOVER_CYC = ITH_RECOVER_CYC,
  parameter int RESET_CYC = ITH_RESET_CYC
) (
  // clock and reset
  input wire logic clock_i,
  input wire logic rstn_i,
  // avalon slave
  input wire logic [4:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  // ide control pins
  output logic ide_reset_n_o,
  output logic ide_cs0_n_o,
  output logic ide_cs1_n_o,
  output logic [2:0] ide_da_o,
  output logic ide_dior_n_o,
  output logic ide_diow_n_o,
  // ide data bus
  input wire logic [15:0] ide_dd_i,
  output logic [15:0] ide_dd_o,
  output logic ide_dd_oe_o,
  // ide device outputs
  input wire logic ide_iordy_i,
  input wire logic ide_intrq_i,
  input wire logic ide_word_transfer_indication_n_i,
  // handshake lines
  input wire logic ide_dasp_n_i,
  output logic ide_dasp_n_o,
  output logic ide_dasp_oe_o,
  input wire logic ide_pdiag_n_i,
  output logic ide_pdiag_n_o,
  output logic ide_pdiag_oe_o
);

  ith_state_s s;
  ith_state_s next_s;
  logic [ITH_SYNC_W-1:0] sync_raw;
  logic [ITH_SYNC_W-1:0] sync_out;
  logic [15:0] dd_s;
  logic iordy_s;
  logic intrq_s;
  logic word_n_s;
  logic dasp_n_s;
  logic pdiag_n_s;
  logic [31:0] read_mux;
  logic [31:0] status_word;
  logic write_acc;
  logic busy;

  assign sync_raw = {ide_dd_i, ide_iordy_i, ide_intrq_i, ide_word_transfer_indication_n_i,
    ide_dasp_n_i, ide_pdiag_n_i};

  ith_sync #(
    .WIDTH(ITH_SYNC_W)
  ) u_sync (
    .clock_i(clock_i),
    .rstn_i(rstn_i),
    .async_i(sync_raw),
    .sync_o(sync_out)
  );

  assign dd_s = sync_out[20:5];
  assign iordy_s = sync_out[4];
  assign intrq_s = sync_out[3];
  assign word_n_s = sync_out[2];
  assign dasp_n_s = sync_out[1];
  assign pdiag_n_s = sync_out[0];

  assign busy = (s.phase != ST_IDLE);
  assign write_acc = avs_write_i && !s.wait_req;

  // status word assembly
  always_comb
  begin
    status_word = 32'h0000_0000;
    status_word[ITH_ST_BUSY] = busy;
    status_word[ITH_ST_DONE] = s.done;
    status_word[ITH_ST_IRQ] = intrq_s;
    status_word[ITH_ST_IRQ_SEEN] = s.irq_seen;
    status_word[ITH_ST_WORD] = !word_n_s;
    status_word[ITH_ST_DASP] = !dasp_n_s;
    status_word[ITH_ST_PDIAG] = !pdiag_n_s;
    status_word[ITH_ST_WFAULT] = s.width_fault;
    status_word[ITH_ST_RESET] = (s.phase == ST_RESET);
  end

  // register read mux
  always_comb
  begin
    read_mux = 32'h0000_0000;
    case (avs_address_i)
      ITH_REG_CTRL:
      begin
        read_mux[ITH_CTRL_READ] = s.cmd.is_read;
        read_mux[ITH_CTRL_BLOCK] = s.cmd.is_block;
        read_mux[ITH_CTRL_ALT] = s.cmd.is_alt;
        read_mux[ITH_CTRL_ADDR +: 3] = s.cmd.addr;
      end
      ITH_REG_WDATA: read_mux[15:0] = s.wdata;
      ITH_REG_RDATA: read_mux[15:0] = s.rdata;
      ITH_REG_STATUS: read_mux = status_word;
      ITH_REG_HRESET: read_mux[0] = (s.phase == ST_RESET);
      ITH_REG_ERRC: read_mux[7:0] = s.err_cause;
      default: read_mux = 32'h0000_0000;
    endcase
  end

  always_comb
  begin
    next_s = s;
    next_s.wait_req = 1'b1;
    next_s.irq_prev = intrq_s;
    if ((avs_read_i || avs_write_i) && s.wait_req)
    begin
      next_s.wait_req = 1'b0;
      if (avs_read_i)
        next_s.readdata = read_mux;
    end
    if (write_acc)
    begin
      case (avs_address_i)
        ITH_REG_WDATA:
        begin
          if (avs_byteenable_i[0])
            next_s.wdata[7:0] = avs_writedata_i[7:0];
          if (avs_byteenable_i[1])
            next_s.wdata[15:8] = avs_writedata_i[15:8];
        end
        ITH_REG_STATUS:
        begin
          if (avs_byteenable_i[0])
          begin
            if (avs_writedata_i[ITH_ST_DONE])
              next_s.done = 1'b0;
            if (avs_writedata_i[ITH_ST_IRQ_SEEN])
              next_s.irq_seen = 1'b0;
            if (avs_writedata_i[ITH_ST_WFAULT])
              next_s.width_fault = 1'b0;
          end
        end
        default:
        begin
        end
      endcase
    end
    // rising interrupt request, set wins over clear
    if (intrq_s && !s.irq_prev)
      next_s.irq_seen = 1'b1;
    case (s.phase)
      ST_IDLE:
      begin
        next_s.pins = ITH_PINS_IDLE;
        if (write_acc && avs_byteenable_i[0] && (avs_address_i == ITH_REG_HRESET)
            && avs_writedata_i[0])
        begin
          next_s.pins.reset_n = 1'b0;
          next_s.cnt = 9'(RESET_CYC - 1);
          next_s.phase = ST_RESET;
        end
        else if (write_acc && avs_byteenable_i[0] && (avs_address_i == ITH_REG_CTRL)
                 && avs_writedata_i[ITH_CTRL_GO])
        begin
          next_s.cmd.is_read = avs_writedata_i[ITH_CTRL_READ];
          next_s.cmd.is_block = avs_writedata_i[ITH_CTRL_BLOCK];
          next_s.cmd.is_alt = avs_writedata_i[ITH_CTRL_ALT];
          next_s.cmd.addr = avs_writedata_i[ITH_CTRL_ADDR +: 3];
          next_s.pins.cs0_n = avs_writedata_i[ITH_CTRL_ALT];
          next_s.pins.cs1_n = !avs_writedata_i[ITH_CTRL_ALT];
          next_s.pins.da = avs_writedata_i[ITH_CTRL_ADDR +: 3];
          if (avs_writedata_i[ITH_CTRL_BLOCK])
            next_s.pins.dd_out = s.wdata;
          else
            next_s.pins.dd_out = {8'h00, s.wdata[7:0]};
          next_s.pins.dd_oe = !avs_writedata_i[ITH_CTRL_READ];
          // a write to the command register clears the held error cause
          if (!avs_writedata_i[ITH_CTRL_READ] && !avs_writedata_i[ITH_CTRL_ALT]
              && (avs_writedata_i[ITH_CTRL_ADDR +: 3] == ITH_TF_COMMAND))
            next_s.err_cause = 8'h00;
          next_s.cnt = 9'(SETUP_CYC - 1);
          next_s.phase = ST_SETUP;
        end
      end
      ST_SETUP:
      begin
        if (s.cnt == 9'h000)
        begin
          if (s.cmd.is_read)
          begin
            next_s.pins.dior_n = 1'b0;
            next_s.cnt = 9'(PULSE_CYC + ITH_SYNC_STAGES - 1);
          end
          else
          begin
            next_s.pins.diow_n = 1'b0;
            next_s.cnt = 9'(PULSE_CYC - 1);
          end
          next_s.phase = ST_STROBE;
        end
        else
          next_s.cnt = s.cnt - 9'h001;
      end
      ST_STROBE:
      begin
        if (s.cnt != 9'h000)
          next_s.cnt = s.cnt - 9'h001;
        else if (iordy_s)
        begin
          next_s.pins.dior_n = 1'b1;
          next_s.pins.diow_n = 1'b1;
          if (s.cmd.is_block && word_n_s)
            next_s.width_fault = 1'b1;
          if (s.cmd.is_read)
          begin
            if (s.cmd.is_block)
              next_s.rdata = dd_s;
            else
              next_s.rdata = {8'h00, dd_s[7:0]};
            if (!s.cmd.is_alt && (s.cmd.addr == ITH_TF_ERROR))
            begin
              next_s.err_cause = dd_s[7:0] & ~ITH_ERR_ZERO_MASK;
            end
            if (!s.cmd.is_alt && (s.cmd.addr == ITH_TF_COMMAND) && !dd_s[ITH_TF_ERR_BIT])
            begin
              next_s.err_cause = 8'h00;
            end
          end
          next_s.cnt = 9'(RECOVER_CYC - 1);
          next_s.phase = ST_RECOVER;
        end
      end
      ST_RECOVER:
      begin
        if (s.cnt == 9'h000)
        begin
          next_s.pins = ITH_PINS_IDLE;
          next_s.done = 1'b1;
          next_s.phase = ST_IDLE;
        end
        else
          next_s.cnt = s.cnt - 9'h001;
      end
      ST_RESET:
      begin
        next_s.pins = ITH_PINS_IDLE;
        next_s.pins.reset_n = 1'b0;
        if (s.cnt == 9'h000)
        begin
          next_s.pins.reset_n = 1'b1;
          next_s.done = 1'b1;
          next_s.phase = ST_IDLE;
        end
        else
          next_s.cnt = s.cnt - 9'h001;
      end
      default:
      begin
        next_s.pins = ITH_PINS_IDLE;
        next_s.phase = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clock_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      s.phase <= ST_RESET;
      s.cnt <= 9'(RESET_CYC - 1);
      s.pins <= '{reset_n: 1'b0, cs0_n: 1'b1, cs1_n: 1'b1, da: 3'h0, dior_n: 1'b1,
        diow_n: 1'b1, dd_out: 16'h0000, dd_oe: 1'b0};
      s.cmd <= '0;
      s.wdata <= 16'h0000;
      s.rdata <= 16'h0000;
      s.err_cause <= 8'h00;
      s.done <= 1'b0;
      s.irq_prev <= 1'b0;
      s.irq_seen <= 1'b0;
      s.width_fault <= 1'b0;
      s.wait_req <= 1'b1;
      s.readdata <= 32'h0000_0000;
    end
    else
    begin
      s <= next_s;
    end
  end

  assign avs_readdata_o = s.readdata;
  assign avs_waitrequest_o = s.wait_req;
  assign ide_reset_n_o = s.pins.reset_n;
  assign ide_cs0_n_o = s.pins.cs0_n;
  assign ide_cs1_n_o = s.pins.cs1_n;
  assign ide_da_o = s.pins.da;
  assign ide_dior_n_o = s.pins.dior_n;
  assign ide_diow_n_o = s.pins.diow_n;
  assign ide_dd_o = s.pins.dd_out;
  assign ide_dd_oe_o = s.pins.dd_oe;
  // handshake lines belong to the drives, host only listens
  assign ide_dasp_n_o = s.cmd.is_read & 1'b0;
  assign ide_dasp_oe_o = s.cmd.is_read & 1'b0;
  assign ide_pdiag_n_o = s.cmd.is_read & 1'b0;
  assign ide_pdiag_oe_o = s.cmd.is_read & 1'b0;

endmodule : ith_host

// *** sim/ith_dev_model.sv ***
`timescale 1ns/10ps
module ith_dev_model (
  // clock and host pins
  input wire logic clock_i,
  input wire logic reset_n_i,
  input wire logic cs0_n_i,
  input wire logic cs1_n_i,
  input wire logic [2:0] da_i,
  input wire logic dior_n_i,
  input wire logic diow_n_i,
  input wire logic [15:0] dd_i,
  // bench controls
  input wire logic [7:0] next_err_i,
  input wire logic slow_i,
  input wire logic [1:0] hs_i,
  // device outputs
  output logic [15:0] dd_o,
  output logic iordy_o,
  output logic intrq_o,
  output logic word_transfer_indication_n_o,
  output logic dasp_n_o,
  output logic pdiag_n_o
);
  logic [15:0] tf [8];
  logic [15:0] rd, last;
  logic [7:0] err;
  logic [1:0] cnt;
  logic irq_set, irq_clr, tfsel;
  assign tfsel = !cs0_n_i && cs1_n_i;
  always_comb
    if (tfsel && da_i == 3'h0)
      rd = tf[0];
    else if (tfsel && da_i == 3'h1)
      rd = {8'h00, err};
    else if (da_i == 3'h7 || !cs1_n_i)
      rd = {9'h000, 1'b1, 5'h00, |err};
    else
      rd = {8'h00, tf[da_i][7:0]};
  // released bus shows the inverse of the last word; error byte mirrored high on data writes
  assign dd_o = (!dior_n_i && (tfsel || !cs1_n_i)) ? rd :
    (!diow_n_i && tfsel && da_i == 3'h0) ? {err, ~last[7:0]} : ~last;
  assign intrq_o = irq_set ^ irq_clr;
  assign word_transfer_indication_n_o = !(tfsel && da_i == 3'h0);
  assign dasp_n_o = !hs_i[0];
  assign pdiag_n_o = !hs_i[1];
  assign iordy_o = !slow_i || cnt == 2'h3;
  always @(posedge clock_i)
    cnt <= (dior_n_i && diow_n_i) ? 2'h0 : cnt + {1'b0, cnt != 2'h3};
  always @(posedge diow_n_i or negedge reset_n_i)
    if (!reset_n_i)
    begin
      tf <= '{default: 16'h0000};
      err <= 8'h00;
      irq_set <= 1'b0;
    end
    else if (tfsel && da_i == 3'h7)
    begin
      err <= next_err_i & 8'hD5;
      irq_set <= !irq_clr;
    end
    else if (tfsel)
      tf[da_i] <= (da_i == 3'h0) ? dd_i : {8'h00, dd_i[7:0]};
  always @(posedge dior_n_i or negedge reset_n_i)
    if (!reset_n_i)
    begin
      last <= 16'h0000;
      irq_clr <= 1'b0;
    end
    else
    begin
      last <= rd;
      if (tfsel && da_i == 3'h7)
        irq_clr <= irq_set;
    end
endmodule : ith_dev_model

// *** sim/ith_host_assertions.sv ***
`timescale 1ns/10ps
module ith_host_assertions
  import ith_pkg::*;
#(
  parameter int RESET_CYC = ITH_RESET_CYC
) (
  // watched ports
  input wire logic clock_i,
  input wire logic rstn_i,
  input wire logic ide_reset_n_o,
  input wire logic ide_cs0_n_o,
  input wire logic ide_cs1_n_o,
  input wire logic [2:0] ide_da_o,
  input wire logic ide_dior_n_o,
  input wire logic ide_diow_n_o,
  input wire logic [15:0] ide_dd_o,
  input wire logic ide_dd_oe_o,
  input wire logic ide_dasp_oe_o,
  input wire logic ide_pdiag_oe_o
);
  logic [8:0] low_cnt;
  always_ff @(posedge clock_i or negedge rstn_i)
    if (!rstn_i)
      low_cnt <= 9'h000;
    else if (ide_reset_n_o)
      low_cnt <= 9'h000;
    else
      low_cnt <= low_cnt + 9'h001;
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!rstn_i);
  property p_one_select;
    (!ide_dior_n_o || !ide_diow_n_o) |-> (ide_cs0_n_o ^ ide_cs1_n_o);
  endproperty
  a_one_select: assert property (p_one_select)
    else $error("strobe without a single chip select");
  property p_addr_steady;
    !ide_dior_n_o && !$past(ide_dior_n_o) |-> $stable(ide_da_o) && $stable(ide_cs0_n_o);
  endproperty
  a_addr_steady: assert property (p_addr_steady)
    else $error("address moved under read strobe");
  property p_write_hold;
    $rose(ide_diow_n_o) |-> ide_dd_oe_o && $stable(ide_dd_o) && $stable(ide_da_o);
  endproperty
  a_write_hold: assert property (p_write_hold)
    else $error("write data not held at strobe rise");
  property p_pulse_min;
    $fell(ide_diow_n_o) |-> !ide_diow_n_o ##1 !ide_diow_n_o;
  endproperty
  a_pulse_min: assert property (p_pulse_min)
    else $error("write strobe too short");
  property p_read_release;
    !ide_dior_n_o |-> !ide_dd_oe_o;
  endproperty
  a_read_release: assert property (p_read_release)
    else $error("host drives bus during read");
  property p_byte_ctrl;
    !ide_cs1_n_o && ide_dd_oe_o |-> ide_dd_o[15:8] == 8'h00;
  endproperty
  a_byte_ctrl: assert property (p_byte_ctrl)
    else $error("upper lane driven on byte access");
  property p_reset_len;
    $rose(ide_reset_n_o) |-> low_cnt >= RESET_CYC - 1 && low_cnt <= RESET_CYC + 1;
  endproperty
  a_reset_len: assert property (p_reset_len)
    else $error("device reset pulse length wrong");
  property p_no_drive;
    !ide_dasp_oe_o && !ide_pdiag_oe_o;
  endproperty
  a_no_drive: assert property (p_no_drive)
    else $error("host drives handshake line");
  c_write: cover property ($fell(ide_diow_n_o));
  c_read: cover property ($fell(ide_dior_n_o));
  c_alt: cover property (!ide_cs1_n_o && !ide_diow_n_o);
endmodule : ith_host_assertions
bind ith_host ith_host_assertions #(.RESET_CYC(RESET_CYC)) ith_host_assertions_i (
  .clock_i, .rstn_i, .ide_reset_n_o, .ide_cs0_n_o, .ide_cs1_n_o, .ide_da_o,
  .ide_dior_n_o, .ide_diow_n_o, .ide_dd_o, .ide_dd_oe_o, .ide_dasp_oe_o, .ide_pdiag_oe_o);

// *** sim/ith_host_tb.sv ***
`timescale 1ns/10ps
module ith_host_tb import ith_pkg::*;;
  typedef struct packed {
    logic alt;
    logic blk;
    logic slow;
    logic [2:0] ad;
    logic [15:0] wd;
    logic [15:0] exp;
  } ith_row_s;
  localparam ith_row_s ROWS [5] = '{
    '{1'b0, 1'b0, 1'b0, 3'h2, 16'h1234, 16'h0034},
    '{1'b0, 1'b0, 1'b1, 3'h3, 16'hABCD, 16'h00CD},
    '{1'b0, 1'b0, 1'b0, 3'h5, 16'h5A5A, 16'h005A},
    '{1'b0, 1'b1, 1'b1, 3'h0, 16'hBEEF, 16'hBEEF},
    '{1'b1, 1'b0, 1'b0, 3'h6, 16'h0002, 16'h0040}};
  localparam logic [7:0] ERRV [7] = '{8'h00, 8'h80, 8'h40, 8'h10, 8'h04, 8'h01, 8'hFF};
  logic clock_i, rstn_i, avs_read_i, avs_write_i, avs_waitrequest_o, slow;
  logic [4:0] avs_address_i;
  logic [31:0] avs_writedata_i, avs_readdata_o, q;
  logic [3:0] avs_byteenable_i;
  logic ide_reset_n_o, ide_cs0_n_o, ide_cs1_n_o, ide_dior_n_o, ide_diow_n_o, ide_dd_oe_o;
  logic [2:0] ide_da_o;
  logic [15:0] ide_dd_o, m_dd, dd_bus;
  logic iordy, intrq, wti_n, dasp_n, pdiag_n;
  logic [7:0] next_err;
  logic [1:0] hs;
  int fails = 0;
  int compares = 0;
  assign dd_bus = ide_dd_oe_o ? ide_dd_o : m_dd;
  ith_host #(.RESET_CYC(4)) ith_host_i (
    .clock_i(clock_i), .rstn_i(rstn_i), .avs_address_i(avs_address_i),
    .avs_read_i(avs_read_i), .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
    .avs_byteenable_i(avs_byteenable_i), .avs_readdata_o(avs_readdata_o),
    .avs_waitrequest_o(avs_waitrequest_o), .ide_reset_n_o(ide_reset_n_o),
    .ide_cs0_n_o(ide_cs0_n_o), .ide_cs1_n_o(ide_cs1_n_o), .ide_da_o(ide_da_o),
    .ide_dior_n_o(ide_dior_n_o), .ide_diow_n_o(ide_diow_n_o), .ide_dd_i(dd_bus),
    .ide_dd_o(ide_dd_o), .ide_dd_oe_o(ide_dd_oe_o), .ide_iordy_i(iordy), .ide_intrq_i(intrq),
    .ide_word_transfer_indication_n_i(wti_n), .ide_dasp_n_i(dasp_n), .ide_dasp_n_o(),
    .ide_dasp_oe_o(), .ide_pdiag_n_i(pdiag_n), .ide_pdiag_n_o(), .ide_pdiag_oe_o());
  ith_dev_model ith_dev_model_i (
    .clock_i(clock_i), .reset_n_i(ide_reset_n_o), .cs0_n_i(ide_cs0_n_o),
    .cs1_n_i(ide_cs1_n_o), .da_i(ide_da_o), .dior_n_i(ide_dior_n_o), .diow_n_i(ide_diow_n_o),
    .dd_i(dd_bus), .next_err_i(next_err), .slow_i(slow), .hs_i(hs), .dd_o(m_dd),
    .iordy_o(iordy), .intrq_o(intrq), .word_transfer_indication_n_o(wti_n),
    .dasp_n_o(dasp_n), .pdiag_n_o(pdiag_n));
  task automatic stop_test();
    if (fails == 0 && compares > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : stop_test
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp)
    begin
      fails++;
      $display("BAD %0t got %h want %h", $time, got, exp);
    end
  endtask : chk
  task automatic av(input logic w, input logic [4:0] a, input logic [31:0] d,
                    output logic [31:0] r);
    int n;
    @(posedge clock_i);
    avs_write_i <= w;
    avs_read_i <= !w;
    avs_address_i <= a;
    avs_writedata_i <= d;
    for (n = 0; n < 20; n++)
    begin
      @(posedge clock_i);
      if (avs_waitrequest_o === 1'b0)
        break;
    end
    r = avs_readdata_o;
    avs_read_i <= 1'b0;
    avs_write_i <= 1'b0;
    if (n == 20)
    begin
      fails++;
      stop_test();
    end
  endtask : av
  task automatic idle();
    logic [31:0] r;
    int n;
    for (n = 0; n < 80; n++)
    begin
      av(1'b0, ITH_REG_STATUS, 32'h0, r);
      if (r[ITH_ST_BUSY] === 1'b0 && r[ITH_ST_RESET] === 1'b0)
        break;
    end
    if (n == 80)
    begin
      fails++;
      stop_test();
    end
  endtask : idle
  task automatic go(input logic r, input logic b, input logic a, input logic [2:0] ad);
    logic [31:0] x;
    av(1'b1, ITH_REG_CTRL, {25'h0, ad, a, b, r, 1'b1}, x);
    idle();
  endtask : go
  initial
  begin
    clock_i = 1'b0;
    forever #50 clock_i = ~clock_i;
  end
  initial
  begin
    rstn_i = 1'b0;
    avs_read_i = 1'b0;
    avs_write_i = 1'b0;
    avs_address_i = 5'h00;
    avs_writedata_i = 32'h0;
    avs_byteenable_i = 4'hF;
    next_err = 8'h00;
    slow = 1'b0;
    hs = 2'h0;
    repeat (5) @(posedge clock_i);
    rstn_i <= 1'b1;
    @(negedge clock_i);
    chk(32'(ide_reset_n_o), 32'h0);
    idle();
    chk(32'(ide_reset_n_o), 32'h1);
    foreach (ROWS[i])
    begin
      slow <= ROWS[i].slow;
      av(1'b1, ITH_REG_WDATA, {16'h0, ROWS[i].wd}, q);
      go(1'b0, ROWS[i].blk, ROWS[i].alt, ROWS[i].ad);
    end
    foreach (ROWS[i])
    begin
      slow <= ROWS[i].slow;
      go(1'b1, ROWS[i].blk, ROWS[i].alt, ROWS[i].ad);
      av(1'b0, ITH_REG_RDATA, 32'h0, q);
      chk(q, {16'h0, ROWS[i].exp});
    end
    av(1'b0, ITH_REG_STATUS, 32'h0, q);
    chk(32'(q[ITH_ST_WFAULT]), 32'h0);
    go(1'b0, 1'b1, 1'b0, 3'h2);
    av(1'b0, ITH_REG_STATUS, 32'h0, q);
    chk(32'(q[ITH_ST_WFAULT]), 32'h1);
    foreach (ERRV[i])
    begin
      next_err <= ERRV[i];
      go(1'b0, 1'b0, 1'b0, ITH_TF_COMMAND);
      av(1'b0, ITH_REG_STATUS, 32'h0, q);
      chk(32'(q[ITH_ST_IRQ]), 32'h1);
      av(1'b0, ITH_REG_ERRC, 32'h0, q);
      chk(q, 32'h0);
      go(1'b1, 1'b0, 1'b0, ITH_TF_ERROR);
      av(1'b0, ITH_REG_ERRC, 32'h0, q);
      chk(q, {24'h0, ERRV[i] & 8'hD5});
      go(1'b1, 1'b0, 1'b0, ITH_TF_COMMAND);
      av(1'b0, ITH_REG_ERRC, 32'h0, q);
      chk(q, {24'h0, ERRV[i] & 8'hD5});
      av(1'b0, ITH_REG_STATUS, 32'h0, q);
      chk(32'(q[ITH_ST_IRQ]), 32'h0);
    end
    av(1'b1, ITH_REG_ERRC, 32'h0, q);
    av(1'b0, ITH_REG_ERRC, 32'h0, q);
    chk(q, 32'hD5);
    av(1'b0, 5'h18, 32'h0, q);
    chk(q, 32'h0);
    go(1'b0, 1'b0, 1'b0, 3'h4);
    av(1'b1, ITH_REG_HRESET, 32'h1, q);
    av(1'b0, ITH_REG_STATUS, 32'h0, q);
    chk(32'(q[ITH_ST_RESET]), 32'h1);
    idle();
    go(1'b1, 1'b0, 1'b0, 3'h4);
    av(1'b0, ITH_REG_RDATA, 32'h0, q);
    chk(q, 32'h0);
    av(1'b0, ITH_REG_STATUS, 32'h0, q);
    chk(32'(q[ITH_ST_DONE] & q[ITH_ST_IRQ_SEEN] & q[ITH_ST_WFAULT]), 32'h1);
    av(1'b1, ITH_REG_STATUS, 32'h8A, q);
    av(1'b0, ITH_REG_STATUS, 32'h0, q);
    chk(32'(q[ITH_ST_DONE] | q[ITH_ST_IRQ_SEEN] | q[ITH_ST_WFAULT]), 32'h0);
    for (int v = 0; v < 4; v++)
    begin
      hs <= 2'(v);
      av(1'b0, ITH_REG_STATUS, 32'h0, q);
      av(1'b0, ITH_REG_STATUS, 32'h0, q);
      chk({30'h0, q[ITH_ST_PDIAG], q[ITH_ST_DASP]}, 32'(v));
    end
    stop_test();
  end
endmodule : ith_host_tb
